// ### logic/audio_clock_divider.sv
// two-stage divider: programmable first stage, fixed eight second stage
module audio_clock_divider import audio_tx_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic audio_tick,
  input wire logic run,
  input wire logic [5:0] div,
  output logic sck,
  output logic sck_fall
);
  typedef struct packed {
    logic [5:0] pre;
    logic [2:0] post;
    logic sck;
    logic fall;
  } state_s;
  state_s st;
  state_s next_st;

  always_comb begin
    next_st = st;
    next_st.fall = 1'b0;
    if (!run) begin
      next_st = '0;
    end else if (audio_tick) begin
      if (st.pre == div) begin
        next_st.pre = 6'h00;
        next_st.post = st.post + 3'h1;
        next_st.sck = next_st.post[2];
        next_st.fall = (st.post == SCK_DIV_LAST);
      end else begin
        next_st.pre = st.pre + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sck = st.sck;
  assign sck_fall = st.fall;

  property p_sck_period;
    @(posedge clk_sys) disable iff (!rst_n)
    st.fall |-> st.post == 3'h0 && $past(st.post) == SCK_DIV_LAST && !st.sck;
  endproperty
  a_sck_period: assert property (p_sck_period) else $error("sck fall off the eight cycle");
endmodule : audio_clock_divider

// ### logic/audio_tx_core.sv
// audio serial transmit path: clock selection and division, fifo, staging, serialiser

// Notes on behaviour
// - registers, bus slave and dma request all run on the system clock.
// - serial side is paced by the audio clock, unrelated to the system clock.
// - a select bit picks the internal or the external audio clock.
// - first divider gives the internal master clock, ratios one to sixty-four.
// - the divider ratio is the programmed field value plus one.
// - the bit clock is the master clock divided by eight.
// - fifo words go left, right alternately, or channel zero up in tdm.
// - the transmit fifo holds 256 words of 32 bits.
// - a hidden four word stage sits between fifo and serial line.
// - trigger event is raised while fifo fill is below the trigger level.
// - freeze with transmit started reads the head without moving read pointer.
// - writes during freeze advance write pointer until fifo is full.
// - the clear bit resets both fifo pointers, emptying it.
// - a status register shows fill count and both pointers.
// - read pointer moves on staging loads outside freeze, write pointer on fifo writes.
// - events: trigger, not full, empty, overflow and underflow.
// - dma request is high when enabled and fill below trigger level.
// - words are right aligned; bits above the sample are zero.
// - tdm frames hold eight channels; inactive ones follow active ones.
module audio_tx_core import audio_tx_pkg::*; #(
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned STAGE = STAGE_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic high_freq_root_clock,
  input wire logic ext_audio_clock,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic transmit_dma_request,
  output logic tx_sck,
  output logic tx_ws,
  output logic tx_sdo
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH) + 1;
  localparam int unsigned SW = $clog2(STAGE) + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [SW-1:0] STAGE_FULL = SW'(STAGE);

  typedef struct packed {
    logic enable;
    logic start;
    fmt_e fmt;
    logic [2:0] chan_cnt;
    logic [2:0] wlen;
    logic [5:0] clk_div;
    logic clk_sel;
    logic [7:0] trig;
    logic clear;
    logic freeze;
    logic req_en;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] used;
    logic [EVT_W-1:0] evt;
    logic [31:0] rdata;
    logic [STAGE-1:0][31:0] stg;
    logic [SW-1:0] stg_cnt;
    logic [31:0] shift;
    logic [4:0] bit_idx;
    logic [2:0] chan;
    logic ws;
    logic sdo;
    logic dma_req;
  } state_s;

  state_s st;
  state_s next_st;
  logic [31:0] fifo_mem [DEPTH];
  logic int_rise;
  logic ext_rise;
  logic audio_tick;
  logic sck_fall;
  logic started;
  logic fifo_wr;
  logic accept;
  logic load_stage;
  logic pop;
  logic consume;
  logic active;
  logic [3:0] nact;
  logic [2:0] frame_last;
  logic [2:0] chan_after;
  logic [2:0] ahead;
  logic [31:0] word;
  logic [31:0] head;

  function automatic logic [5:0] word_bits(input logic [2:0] code);
    case (code)
      3'h0: word_bits = 6'd8;
      3'h1: word_bits = 6'd16;
      3'h2: word_bits = 6'd18;
      3'h3: word_bits = 6'd20;
      3'h4: word_bits = 6'd24;
      default: word_bits = 6'd32;
    endcase
  endfunction : word_bits

  // sample sits in the low bits; move it to the msb end for serial output
  function automatic logic [31:0] align_word(input logic [31:0] w, input logic [2:0] code);
    logic [5:0] wb;
    logic [31:0] mask;
    wb = word_bits(code);
    mask = (wb == 6'd32) ? 32'hFFFF_FFFF : ((32'h1 << wb) - 32'h1);
    align_word = (w & mask) << (6'd32 - wb);
  endfunction : align_word

  function automatic logic is_fifo_port(input logic [7:0] a);
    is_fifo_port = (a == OFS_FIFO_WRITE) || (a == OFS_FIFO_WRITE_SILENT);
  endfunction : is_fifo_port

  // audio clocks never clock flops here; they are sampled as pins
  pin_sync u_int_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(high_freq_root_clock),
    .rise(int_rise)
  );
  pin_sync u_ext_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(ext_audio_clock),
    .rise(ext_rise)
  );

  assign audio_tick = st.clk_sel ? ext_rise : int_rise;

  audio_clock_divider u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .audio_tick(audio_tick),
    .run(started),
    .div(st.clk_div),
    .sck(tx_sck),
    .sck_fall(sck_fall)
  );

  assign head = fifo_mem[st.rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (accept) begin
      fifo_mem[st.wr_ptr] <= wdata;
    end
  end

  always_comb begin
    next_st = st;
    started = st.enable & st.start;
    fifo_wr = wr_en & is_fifo_port(addr) & ~st.clear;
    accept = fifo_wr & (st.used != FULL_COUNT);
    consume = 1'b0;
    active = 1'b0;
    word = 32'h0000_0000;
    nact = (st.fmt == FMT_TDM) ? ({1'b0, st.chan_cnt} + 4'h1) : 4'(STEREO_CHANNELS);
    frame_last = (st.fmt == FMT_TDM) ? 3'(TDM_CHANNELS - 1) : 3'(STEREO_CHANNELS - 1);
    chan_after = (st.chan == frame_last) ? 3'h0 : st.chan + 3'h1;
    ahead = (st.bit_idx == 5'h1F) ? chan_after : st.chan;
    next_st.rdata = 32'h0000_0000;

    // register writes
    if (wr_en) begin
      case (addr)
        OFS_AUDIO_CONTROL: begin
          next_st.enable = wdata[CTL_ENABLE_BIT];
          next_st.start = wdata[CTL_START_BIT];
          next_st.fmt = fmt_e'(wdata[CTL_FMT_LSB +: 2]);
          next_st.chan_cnt = wdata[CTL_CHAN_LSB +: 3];
          next_st.wlen = wdata[CTL_WLEN_LSB +: 3];
        end
        OFS_AUDIO_CLOCK_CONTROL: begin
          next_st.clk_div = wdata[CLK_DIV_LSB +: 6];
          next_st.clk_sel = wdata[CLK_SEL_BIT];
        end
        OFS_TRANSMIT_FIFO_CONTROL: begin
          next_st.trig = wdata[FCTL_TRIG_LSB +: 8];
          next_st.clear = wdata[FCTL_CLEAR_BIT];
          next_st.freeze = wdata[FCTL_FREEZE_BIT];
        end
        OFS_DMA_TRIGGER_CONTROL: begin
          next_st.req_en = wdata[DMA_REQ_EN_BIT];
        end
        OFS_EVENT_STATUS: begin
          next_st.evt = st.evt & ~wdata[EVT_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // register reads, answered the cycle after the strobe
    if (rd_en) begin
      case (addr)
        OFS_AUDIO_CONTROL: begin
          next_st.rdata[CTL_ENABLE_BIT] = st.enable;
          next_st.rdata[CTL_START_BIT] = st.start;
          next_st.rdata[CTL_FMT_LSB +: 2] = st.fmt;
          next_st.rdata[CTL_CHAN_LSB +: 3] = st.chan_cnt;
          next_st.rdata[CTL_WLEN_LSB +: 3] = st.wlen;
        end
        OFS_AUDIO_CLOCK_CONTROL: begin
          next_st.rdata[CLK_DIV_LSB +: 6] = st.clk_div;
          next_st.rdata[CLK_SEL_BIT] = st.clk_sel;
        end
        OFS_TRANSMIT_FIFO_CONTROL: begin
          next_st.rdata[FCTL_TRIG_LSB +: 8] = st.trig;
          next_st.rdata[FCTL_CLEAR_BIT] = st.clear;
          next_st.rdata[FCTL_FREEZE_BIT] = st.freeze;
        end
        OFS_DMA_TRIGGER_CONTROL: begin
          next_st.rdata[DMA_REQ_EN_BIT] = st.req_en;
        end
        OFS_FIFO_STATUS: begin
          next_st.rdata[STAT_USED_LSB +: CW] = st.used;
          next_st.rdata[STAT_RD_LSB +: PW] = st.rd_ptr;
          next_st.rdata[STAT_WR_LSB +: PW] = st.wr_ptr;
        end
        OFS_EVENT_STATUS: begin
          next_st.rdata[EVT_W-1:0] = st.evt;
        end
        default: begin
        end
      endcase
    end

    // serialiser, one bit per falling bit clock
    if (!started) begin
      next_st.bit_idx = 5'h00;
      next_st.chan = 3'h0;
      next_st.sdo = 1'b0;
      next_st.ws = 1'b0;
      next_st.shift = 32'h0000_0000;
    end else if (sck_fall) begin
      if (st.bit_idx == 5'h00) begin
        active = {1'b0, st.chan} < nact;
        if (active && st.stg_cnt != '0) begin
          word = align_word(st.stg[0], st.wlen);
          consume = 1'b1;
        end else if (active) begin
          next_st.evt[EVT_UNDERFLOW] = 1'b1;
        end
        next_st.sdo = word[31];
        next_st.shift = word << 1;
      end else begin
        next_st.sdo = st.shift[31];
        next_st.shift = st.shift << 1;
      end
      next_st.bit_idx = st.bit_idx + 5'h01;
      if (st.bit_idx == 5'h1F) begin
        next_st.chan = chan_after;
      end
      // i2s switches word select one bit early, lj on the boundary
      case (st.fmt)
        FMT_LJ: next_st.ws = ~st.chan[0];
        FMT_TDM: next_st.ws = (st.chan == 3'h0);
        default: next_st.ws = ahead[0];
      endcase
    end

    // staging buffer: drain first, then refill from the fifo head
    if (consume) begin
      // last slot written apart so no index runs past the stage
      for (int i = 0; i < STAGE - 1; i++) begin
        next_st.stg[i] = st.stg[i + 1];
      end
      next_st.stg[STAGE - 1] = 32'h0000_0000;
      next_st.stg_cnt = st.stg_cnt - SW'(1);
    end
    load_stage = started && st.used != '0 && next_st.stg_cnt != STAGE_FULL && !st.clear;
    pop = load_stage & ~st.freeze;
    if (load_stage) begin
      next_st.stg[next_st.stg_cnt[SW-2:0]] = head;
      next_st.stg_cnt = next_st.stg_cnt + SW'(1);
    end
    // a disabled transmitter drops whatever it had staged
    if (!st.enable) begin
      next_st.stg_cnt = '0;
    end

    // fifo pointers
    next_st.wr_ptr = st.wr_ptr + PW'(accept);
    next_st.rd_ptr = st.rd_ptr + PW'(pop);
    next_st.used = st.used + CW'(accept) - CW'(pop);
    if (st.clear) begin
      next_st.wr_ptr = '0;
      next_st.rd_ptr = '0;
      next_st.used = '0;
    end

    // sticky events; a set in the clearing cycle wins
    if (fifo_wr && !accept && addr == OFS_FIFO_WRITE) begin
      next_st.evt[EVT_OVERFLOW] = 1'b1;
    end
    if (st.used < CW'(st.trig)) begin
      next_st.evt[EVT_TRIGGER] = 1'b1;
    end
    if (st.used != FULL_COUNT) begin
      next_st.evt[EVT_NOT_FULL] = 1'b1;
    end
    if (st.used == '0) begin
      next_st.evt[EVT_EMPTY] = 1'b1;
    end
    next_st.dma_req = st.req_en && (st.used < CW'(st.trig));
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.fmt <= FMT_I2S;
      st.chan_cnt <= RST_CHAN;
      st.wlen <= RST_WLEN;
      st.clk_div <= RST_CLK_DIV;
      st.trig <= RST_TRIG;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign transmit_dma_request = st.dma_req;
  assign tx_ws = st.ws;
  assign tx_sdo = st.sdo;

  property p_dma_level;
    @(posedge clk_sys) disable iff (!rst_n)
    st.req_en && st.used < CW'(st.trig) |=> transmit_dma_request;
  endproperty
  a_dma_level: assert property (p_dma_level) else $error("dma request missing");

  property p_dma_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
    !st.req_en || st.used >= CW'(st.trig) |=> !transmit_dma_request;
  endproperty
  a_dma_quiet: assert property (p_dma_quiet) else $error("dma request spurious");

  property p_trigger_event;
    @(posedge clk_sys) disable iff (!rst_n)
    st.used < CW'(st.trig) |=> st.evt[EVT_TRIGGER];
  endproperty
  a_trigger_event: assert property (p_trigger_event) else $error("trigger event lost");

  property p_clear_empties;
    @(posedge clk_sys) disable iff (!rst_n)
    st.clear |=> st.wr_ptr == '0 && st.rd_ptr == '0 && st.used == '0;
  endproperty
  a_clear_empties: assert property (p_clear_empties) else $error("clear left data");

  property p_freeze_holds;
    @(posedge clk_sys) disable iff (!rst_n)
    st.freeze && !st.clear |=> $stable(st.rd_ptr);
  endproperty
  a_freeze_holds: assert property (p_freeze_holds) else $error("read pointer moved in freeze");

  property p_write_advances;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_en && is_fifo_port(addr) && !st.clear && st.used != FULL_COUNT
      |=> st.wr_ptr == PW'($past(st.wr_ptr) + 1'b1);
  endproperty
  a_write_advances: assert property (p_write_advances) else $error("write pointer stuck");

  property p_full_stops;
    @(posedge clk_sys) disable iff (!rst_n)
    st.used == FULL_COUNT && !st.clear |=> $stable(st.wr_ptr);
  endproperty
  a_full_stops: assert property (p_full_stops) else $error("write pointer ran past full");

  property p_overflow_flag;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_en && addr == OFS_FIFO_WRITE && !st.clear && st.used == FULL_COUNT
      |=> st.evt[EVT_OVERFLOW];
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("overflow not flagged");

  property p_fill_bound;
    @(posedge clk_sys) disable iff (!rst_n)
    st.used <= FULL_COUNT && st.stg_cnt <= STAGE_FULL;
  endproperty
  a_fill_bound: assert property (p_fill_bound) else $error("fifo or stage overfilled");
endmodule : audio_tx_core

// ### logic/audio_tx_pkg.sv
// constants and types shared by the audio transmit clocking and fifo block
package audio_tx_pkg;
  localparam int unsigned FIFO_DEPTH = 256;
  localparam int unsigned STAGE_DEPTH = 4;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned TDM_CHANNELS = 8;
  localparam int unsigned STEREO_CHANNELS = 2;
  localparam logic [2:0] SCK_DIV_LAST = 3'h7;
  localparam logic [7:0] OFS_AUDIO_CONTROL = 8'h00;
  localparam logic [7:0] OFS_AUDIO_CLOCK_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TRANSMIT_FIFO_CONTROL = 8'h08;
  localparam logic [7:0] OFS_DMA_TRIGGER_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_FIFO_WRITE = 8'h10;
  localparam logic [7:0] OFS_FIFO_WRITE_SILENT = 8'h14;
  localparam logic [7:0] OFS_FIFO_STATUS = 8'h18;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h1C;
  localparam int unsigned CTL_ENABLE_BIT = 0;
  localparam int unsigned CTL_START_BIT = 1;
  localparam int unsigned CTL_FMT_LSB = 2;
  localparam int unsigned CTL_CHAN_LSB = 4;
  localparam int unsigned CTL_WLEN_LSB = 8;
  localparam int unsigned CLK_DIV_LSB = 0;
  localparam int unsigned CLK_SEL_BIT = 8;
  localparam int unsigned FCTL_TRIG_LSB = 0;
  localparam int unsigned FCTL_CLEAR_BIT = 16;
  localparam int unsigned FCTL_FREEZE_BIT = 17;
  localparam int unsigned DMA_REQ_EN_BIT = 0;
  localparam int unsigned STAT_USED_LSB = 0;
  localparam int unsigned STAT_RD_LSB = 16;
  localparam int unsigned STAT_WR_LSB = 24;
  localparam int unsigned EVT_TRIGGER = 0;
  localparam int unsigned EVT_NOT_FULL = 1;
  localparam int unsigned EVT_EMPTY = 2;
  localparam int unsigned EVT_OVERFLOW = 3;
  localparam int unsigned EVT_UNDERFLOW = 4;
  localparam int unsigned EVT_W = 5;
  localparam logic [5:0] RST_CLK_DIV = 6'h00;
  localparam logic [7:0] RST_TRIG = 8'h00;
  localparam logic [2:0] RST_CHAN = 3'h1;
  localparam logic [2:0] RST_WLEN = 3'h5;
  typedef enum logic [1:0] {FMT_I2S, FMT_LJ, FMT_TDM} fmt_e;
endpackage : audio_tx_pkg

// ### logic/pin_sync.sv
// three-stage synchroniser giving a one-cycle pulse on each settled rising edge
module pin_sync (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } state_s;
  state_s st;
  state_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rise = 1'b0;
    // a change counts only once stages two and three agree
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
      next_st.rise = st.s3 & ~st.level;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = st.rise;
endmodule : pin_sync

// ### verif/audio_codec_model.sv
// behavioural codec: free-running host master clock and serial word receiver
module audio_codec_model #(
  parameter int EXT_HALF = 24
) (
  input wire logic listen,
  input wire logic tx_sck,
  input wire logic tx_ws,
  input wire logic tx_sdo,
  output logic ext_audio_clock,
  output logic [31:0] last_word,
  output logic last_ws,
  output logic [7:0] word_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic armed = 1'b0;
  logic [31:0] sh = 32'h0;
  int nbit = 0;

  // host master clock runs free, like a crystal on the board
  initial begin
    ext_audio_clock = 1'b0;
    forever #(EXT_HALF) ext_audio_clock = ~ext_audio_clock;
  end

  initial begin
    last_word = 32'h0;
    last_ws = 1'b0;
    word_count = 8'h00;
  end

  // first falling edge marks the first bit of the frame
  always @(negedge tx_sck or negedge listen) begin
    armed <= listen;
  end

  // msb first, sampled on the rising edge
  always @(posedge tx_sck or negedge listen) begin
    if (!listen) begin
      nbit = 0;
      word_count = 8'h00;
    end else if (armed) begin
      sh = {sh[30:0], tx_sdo};
      nbit = nbit + 1;
      if (nbit == 16) begin
        last_ws = tx_ws;
      end
      if (nbit == 32) begin
        last_word = sh;
        word_count = word_count + 8'h01;
        nbit = 0;
      end
    end
  end
endmodule : audio_codec_model

// ### verif/tb_top.sv
// self-checking bench for the audio transmit clocking and fifo block
module tb_top import audio_tx_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] RA [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
    8'h20};
  localparam logic [31:0] RV [9] = '{32'h510, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h6, 32'h0};
  localparam logic [31:0] DV [3] = '{32'h2, 32'h100, 32'h3F};
  localparam logic [31:0] DP [3] = '{32'd960, 32'd384, 32'd20480};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hf = 1'b0;
  logic ext;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic dreq;
  logic tx_sck;
  logic tx_ws;
  logic tx_sdo;
  logic listen = 1'b0;
  logic [31:0] lw;
  logic lws;
  logic [7:0] wc;
  int err_total = 0;
  int checks_done = 0;

  audio_tx_core #(.DEPTH(FIFO_DEPTH), .STAGE(STAGE_DEPTH)) audio_tx_core_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .high_freq_root_clock(hf),
    .ext_audio_clock(ext),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .transmit_dma_request(dreq),
    .tx_sck(tx_sck),
    .tx_ws(tx_ws),
    .tx_sdo(tx_sdo)
  );

  audio_codec_model audio_codec_model_inst (
    .listen(listen),
    .tx_sck(tx_sck),
    .tx_ws(tx_ws),
    .tx_sdo(tx_sdo),
    .ext_audio_clock(ext),
    .last_word(lw),
    .last_ws(lws),
    .word_count(wc)
  );

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // offset so internal audio clock edges never meet system clock edges
  initial begin
    #1;
    forever #20 hf = ~hf;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp, "register read");
  endtask : rd

  // waits for serial word n, bounded
  task automatic rx(input int n, input logic [31:0] exp, input logic expws);
    int i;
    for (i = 0; i < 30000 && wc < n[7:0]; i++) @(posedge clk_sys);
    // a word that never arrives is a mismatch, not a stale compare
    chk({24'h0, wc}, n, "word count");
    chk(lw, exp, "serial word");
    chk({31'h0, lws}, {31'h0, expws}, "word select");
  endtask : rx

  task automatic go(input logic [31:0] ctl);
    @(posedge clk_sys);
    listen <= 1'b1;
    wr(OFS_AUDIO_CONTROL, ctl);
  endtask : go

  task automatic idle;
    wr(OFS_AUDIO_CONTROL, 32'h0);
    listen <= 1'b0;
    wr(OFS_TRANSMIT_FIFO_CONTROL, 32'h0001_0004);
    wr(OFS_TRANSMIT_FIFO_CONTROL, 32'h4);
    wr(OFS_EVENT_STATUS, 32'h1F);
  endtask : idle

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // a hang costs a mismatch; normal run is well under this
  initial begin
    #350000;
    err_total++;
    final_report();
  end

  initial begin
    int i;
    time t0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 9; i++) rd(RA[i], RV[i]);
    done("reset values");
    wr(OFS_TRANSMIT_FIFO_CONTROL, 32'h4);
    wr(OFS_DMA_TRIGGER_CONTROL, 32'h1);
    wr(OFS_EVENT_STATUS, 32'h1F);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, dreq}, 32'h1, "dma request");
    rd(OFS_EVENT_STATUS, 32'h7);
    for (i = 0; i < 4; i++) wr(OFS_FIFO_WRITE, i);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, dreq}, 32'h0, "dma request");
    rd(OFS_FIFO_STATUS, 32'h0400_0004);
    wr(OFS_TRANSMIT_FIFO_CONTROL, 32'h0001_0004);
    rd(OFS_FIFO_STATUS, 32'h0);
    wr(OFS_TRANSMIT_FIFO_CONTROL, 32'h4);
    done("trigger and clear");
    for (i = 0; i < 256; i++) wr(OFS_FIFO_WRITE, i);
    rd(OFS_FIFO_STATUS, 32'h100);
    wr(OFS_EVENT_STATUS, 32'h1F);
    rd(OFS_EVENT_STATUS, 32'h0);
    wr(OFS_FIFO_WRITE_SILENT, 32'h0);
    rd(OFS_EVENT_STATUS, 32'h0);
    wr(OFS_FIFO_WRITE, 32'h0);
    rd(OFS_EVENT_STATUS, 32'h8);
    rd(OFS_FIFO_STATUS, 32'h100);
    idle();
    done("full fifo");
    wr(OFS_FIFO_WRITE, 32'h1234_5678);
    wr(OFS_FIFO_WRITE, 32'h9ABC_DEF0);
    go(32'h513);
    rx(1, 32'h1234_5678, 1'b0);
    rx(2, 32'h9ABC_DEF0, 1'b1);
    rd(OFS_FIFO_STATUS, 32'h0202_0000);
    rx(3, 32'h0, 1'b0);
    rd(OFS_EVENT_STATUS, 32'h17);
    idle();
    done("i2s stereo");
    wr(OFS_FIFO_WRITE, 32'h0000_ABCD);
    wr(OFS_FIFO_WRITE, 32'h0000_1234);
    go(32'h117);
    rx(1, 32'hABCD_0000, 1'b1);
    rx(2, 32'h1234_0000, 1'b0);
    idle();
    done("left justified 16 bit");
    wr(OFS_FIFO_WRITE, 32'h00C0_FFEE);
    go(32'h50B);
    rx(1, 32'h00C0_FFEE, 1'b1);
    rx(2, 32'h0, 1'b0);
    idle();
    done("tdm");
    wr(OFS_FIFO_WRITE, 32'h00AB_CDEF);
    wr(OFS_FIFO_WRITE, 32'h0000_0321);
    go(32'h413);
    rx(1, 32'hABCD_EF00, 1'b0);
    rx(2, 32'h0003_2100, 1'b1);
    idle();
    done("i2s 24 bit");
    wr(OFS_FIFO_WRITE, 32'h1111_0001);
    wr(OFS_FIFO_WRITE, 32'h2222_0002);
    wr(OFS_TRANSMIT_FIFO_CONTROL, 32'h0002_0004);
    go(32'h513);
    rx(1, 32'h1111_0001, 1'b0);
    rx(2, 32'h1111_0001, 1'b1);
    wr(OFS_FIFO_WRITE, 32'h3333_0003);
    rd(OFS_FIFO_STATUS, 32'h0300_0003);
    wr(OFS_AUDIO_CONTROL, 32'h0);
    listen <= 1'b0;
    wr(OFS_TRANSMIT_FIFO_CONTROL, 32'h4);
    go(32'h513);
    rx(1, 32'h1111_0001, 1'b0);
    rx(2, 32'h2222_0002, 1'b1);
    idle();
    done("freeze");
    for (i = 0; i < 3; i++) begin
      wr(OFS_AUDIO_CLOCK_CONTROL, DV[i]);
      go(32'h513);
      @(posedge tx_sck);
      t0 = $time;
      @(posedge tx_sck);
      chk(32'($time - t0), DP[i], "bit clock period");
      idle();
    end
    done("dividers");
    final_report();
  end
endmodule : tb_top
